// [rtl/wim_defines.vh]
// constants for the wake input monitor: modes, field codes and filter times
// assumes a 20 MHz core clock; included by the monitor and its pin channel
// ==========================================
// Operation
// - both edges on each wake pin count
// - interrupt in normal/stop, wake in sleep/fail-safe
// - static sense continuous, cyclic only in window
// - filter restarts on cross-back, accepts after time
// - per-pin wake enable; disabled pins never wake
// - per-pin wake source flags, always readable
// - level status in normal and stop modes
// - cyclic sense shows last window sample
// - alternate pins: fixed short filter, own flags
// - pull codes: none, down, up
// - pull code 11 follows detected level
// - filter codes: 16us, 64us, cyclic a, b
// - measurement path only in normal mode
// - measurement replaces pins one and two signalling
// - switch closed only when enabled and normal
// - measurement gates pulls, signals and flags
// - sleep with only pins one/two: fail, restart
`ifndef WIM_DEFINES_VH
`define WIM_DEFINES_VH

// ==========================================
// device modes
`define WIM_MODE_NORMAL 3'h0
`define WIM_MODE_STOP 3'h1
`define WIM_MODE_SLEEP 3'h2
`define WIM_MODE_FAILSAFE 3'h3
`define WIM_MODE_RESTART 3'h4

// ==========================================
// pull select codes
`define WIM_PULL_NONE 2'h0
`define WIM_PULL_DOWN 2'h1
`define WIM_PULL_UP 2'h2
`define WIM_PULL_AUTO 2'h3

// ==========================================
// filter select codes
`define WIM_FLT_STATIC_SHORT 2'h0
`define WIM_FLT_STATIC_LONG 2'h1
`define WIM_FLT_CYCLIC_A 2'h2
`define WIM_FLT_CYCLIC_B 2'h3

// ==========================================
// filter times
`define WIM_CLK_HZ 20000000
`define WIM_SHORT_FILTER_US 16
`define WIM_LONG_FILTER_US 64
// 16 us and 64 us in 20 MHz cycles, sized to the filter counter
`define WIM_SHORT_FILTER_CYC 11'h140
`define WIM_LONG_FILTER_CYC 11'h500
`define WIM_FILTER_CNT_W 11

// ==========================================
// reset values
`define WIM_RST_LEVEL 1'h0

`endif

// [rtl/wim_pin_chan.v]
// one wake pin channel: three-stage synchroniser, both-edge filter, level hold
// assumes a raw pin from another domain; gate and window come from the same clock
`include "wim_defines.vh"

module wim_pin_chan (
	clk,
	rst,
	pin,
	active,
	long_sel,
	event_p,
	level
);
	input wire clk;
	input wire rst;
	input wire pin;
	input wire active;
	input wire long_sel;
	output reg event_p;
	output reg level;

	// ==========================================
	// synchroniser
	reg s1_q;
	reg s2_q;
	reg s3_q;
	always @(posedge clk) begin
		if (rst) begin
			s1_q <= 1'h0;
			s2_q <= 1'h0;
			s3_q <= 1'h0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	// a change counts only once stages two and three agree
	wire stable = (s2_q == s3_q);

	// ==========================================
	// filter
	localparam [10:0] short_cyc = `WIM_SHORT_FILTER_CYC;
	localparam [10:0] long_cyc = `WIM_LONG_FILTER_CYC;
	reg [10:0] cnt_q;
	reg busy_q;
	wire [10:0] limit = long_sel ? long_cyc : short_cyc;

	always @(posedge clk) begin
		if (rst) begin
			cnt_q <= 11'h0;
			busy_q <= 1'h0;
			event_p <= 1'h0;
			level <= `WIM_RST_LEVEL;
		end else begin
			event_p <= 1'h0;
			if (!active) begin
				// outside the window the filter is dropped; level keeps last sample
				busy_q <= 1'h0;
				cnt_q <= 11'h0;
			end else if (stable && s3_q != level) begin
				// a crossing in either direction starts or continues the filter
				if (!busy_q) begin
					busy_q <= 1'h1;
					cnt_q <= 11'h1;
				end else if (cnt_q >= limit - 11'h1) begin
					busy_q <= 1'h0;
					cnt_q <= 11'h0;
					level <= s3_q;
					event_p <= 1'h1;
				end else begin
					cnt_q <= cnt_q + 11'h1;
				end
			end else if (stable) begin
				// crossed back before the filter ran out: reject
				busy_q <= 1'h0;
				cnt_q <= 11'h0;
			end else if (busy_q) begin
				cnt_q <= cnt_q + 11'h1;
			end
		end
	end
endmodule // wim_pin_chan

// [rtl/wim_wake_monitor.v]
// wake input monitor: three high-voltage wake pins and two alternate fail-safe pins
// assumes mode, control bits, timer windows and flag clears come from the same clock
`include "wim_defines.vh"

module wim_wake_monitor #(
	parameter N_WAKE = 3,
	parameter N_ALT = 2
) (
	clk,
	rst,
	hv_wake_pin,
	failsafe_out_pins,
	alt_pin_as_wake,
	dev_mode,
	sleep_cmd,
	wake_enable_ctrl,
	pull_source_ctrl,
	filter_mode_ctrl,
	meas_path_enable,
	cyclic_timer_a_win,
	cyclic_timer_b_win,
	wake_flag_clr,
	alt_flag_clr,
	wake_source_flags,
	alt_pin_wake_flags,
	pin_level_status,
	pull_up_en,
	pull_down_en,
	meas_switch,
	wake_irq,
	wake_up_req,
	spi_fail_set,
	restart_req
);
	input wire clk;
	input wire rst;
	input wire [N_WAKE-1:0] hv_wake_pin;
	input wire [N_ALT-1:0] failsafe_out_pins;
	input wire [N_ALT-1:0] alt_pin_as_wake;
	input wire [2:0] dev_mode;
	input wire sleep_cmd;
	input wire [N_WAKE-1:0] wake_enable_ctrl;
	input wire [2*N_WAKE-1:0] pull_source_ctrl;
	input wire [2*N_WAKE-1:0] filter_mode_ctrl;
	input wire meas_path_enable;
	input wire cyclic_timer_a_win;
	input wire cyclic_timer_b_win;
	input wire [N_WAKE-1:0] wake_flag_clr;
	input wire [N_ALT-1:0] alt_flag_clr;
	output reg [N_WAKE-1:0] wake_source_flags;
	output reg [N_ALT-1:0] alt_pin_wake_flags;
	output reg [N_WAKE-1:0] pin_level_status;
	output reg [N_WAKE-1:0] pull_up_en;
	output reg [N_WAKE-1:0] pull_down_en;
	output reg meas_switch;
	output reg wake_irq;
	output reg wake_up_req;
	output reg spi_fail_set;
	output reg restart_req;

	// ==========================================
	// mode decode
	function is_awake_mode;
		input [2:0] m;
		begin
			is_awake_mode = (m == `WIM_MODE_NORMAL) || (m == `WIM_MODE_STOP);
		end
	endfunction

	function is_low_power_mode;
		input [2:0] m;
		begin
			is_low_power_mode = (m == `WIM_MODE_SLEEP) || (m == `WIM_MODE_FAILSAFE);
		end
	endfunction

	wire normal_mode = (dev_mode == `WIM_MODE_NORMAL);
	wire awake = is_awake_mode(dev_mode);
	wire low_power = is_low_power_mode(dev_mode);

	// ==========================================
	// wake pin channels
	wire [N_WAKE-1:0] ev;
	wire [N_WAKE-1:0] lvl;
	wire [N_WAKE-1:0] gated;
	wire [N_WAKE-1:0] win;

	genvar i;
	generate
		for (i = 0; i < N_WAKE; i = i + 1) begin : g_wake
			wire [1:0] flt = filter_mode_ctrl[2*i+1:2*i];
			// pins one and two hand over to the measurement path when it is enabled
			assign gated[i] = (i < 2) && meas_path_enable;
			// cyclic sense listens only inside its timer window
			assign win[i] = !flt[1] ? 1'h1 :
				(flt[0] ? cyclic_timer_b_win : cyclic_timer_a_win);
			wim_pin_chan u_chan (
				.clk(clk),
				.rst(rst),
				.pin(hv_wake_pin[i]),
				.active(win[i] && !gated[i]),
				.long_sel(flt == `WIM_FLT_STATIC_LONG),
				.event_p(ev[i]),
				.level(lvl[i])
			);
		end
	endgenerate

	// ==========================================
	// alternate fail-safe pins, always static with the short filter
	wire [N_ALT-1:0] alt_ev;
	generate
		for (i = 0; i < N_ALT; i = i + 1) begin : g_alt
			wim_pin_chan u_alt (
				.clk(clk),
				.rst(rst),
				.pin(failsafe_out_pins[i]),
				.active(alt_pin_as_wake[i]),
				.long_sel(1'h0),
				.event_p(alt_ev[i]),
				.level()
			);
		end
	endgenerate

	// a disabled pin is still filtered for its level but never wakes; a gated pin is not filtered and never wakes
	wire [N_WAKE-1:0] qual = ev & wake_enable_ctrl & ~gated;
	wire [N_ALT-1:0] alt_qual = alt_ev & alt_pin_as_wake;
	wire any_wake = (|qual) || (|alt_qual);

	// only pins one and two would be left to wake the device
	wire only_gated_src = meas_path_enable && (|wake_enable_ctrl[1:0]) &&
		!(|(wake_enable_ctrl & ~{{(N_WAKE-2){1'h0}}, 2'h3})) && !(|alt_pin_as_wake);

	// ==========================================
	// flags, levels and pulls
	integer k;
	always @(posedge clk) begin
		if (rst) begin
			wake_source_flags <= {N_WAKE{1'h0}};
			alt_pin_wake_flags <= {N_ALT{1'h0}};
			pin_level_status <= {N_WAKE{`WIM_RST_LEVEL}};
			pull_up_en <= {N_WAKE{1'h0}};
			pull_down_en <= {N_WAKE{1'h0}};
			meas_switch <= 1'h0;
			wake_irq <= 1'h0;
			wake_up_req <= 1'h0;
			spi_fail_set <= 1'h0;
			restart_req <= 1'h0;
		end else begin
			// set wins over a clear arriving in the same cycle
			wake_source_flags <= (wake_source_flags & ~wake_flag_clr) | qual;
			alt_pin_wake_flags <= (alt_pin_wake_flags & ~alt_flag_clr) | alt_qual;
			for (k = 0; k < N_WAKE; k = k + 1) begin
				// level register freezes for gated pins and outside normal/stop
				if (awake && !gated[k]) begin
					pin_level_status[k] <= lvl[k];
				end
				case (gated[k] ? `WIM_PULL_NONE : pull_source_ctrl[2*k+1 -: 2])
					`WIM_PULL_DOWN: begin
						pull_up_en[k] <= 1'h0;
						pull_down_en[k] <= 1'h1;
					end
					`WIM_PULL_UP: begin
						pull_up_en[k] <= 1'h1;
						pull_down_en[k] <= 1'h0;
					end
					`WIM_PULL_AUTO: begin
						// keep the pin where it is: reinforces the detected level
						pull_up_en[k] <= lvl[k];
						pull_down_en[k] <= !lvl[k];
					end
					default: begin
						pull_up_en[k] <= 1'h0;
						pull_down_en[k] <= 1'h0;
					end
				endcase
			end
			meas_switch <= meas_path_enable && normal_mode;
			wake_irq <= any_wake && awake;
			wake_up_req <= any_wake && low_power;
			spi_fail_set <= sleep_cmd && only_gated_src;
			restart_req <= sleep_cmd && only_gated_src;
		end
	end
endmodule // wim_wake_monitor

// [verif/wim_switch_model.sv]
// far-side model: switches on the wake pins and on the alternate pins
// assumes the bench sets contact levels between clock edges and says which contacts are powered
module wim_switch_model (
	input wire [2:0] lvl,
	input wire [1:0] alt_lvl,
	input wire [2:0] supply_on,
	output wire [2:0] hv_wake_pin,
	output wire [1:0] failsafe_out_pins
);
	timeunit 1ns;
	timeprecision 1ns;
	// contacts drive hard levels, so the pull sources never decide a pin
	// a contact fed from an unpowered high-side output reads low
	assign hv_wake_pin = lvl & supply_on;
	assign failsafe_out_pins = alt_lvl;
endmodule // wim_switch_model

// [verif/wim_check_monitor.sv]
// concurrent checks on the wake input monitor top-level ports
// assumes one clock domain with synchronous active-high reset
module wim_wake_checker #(
	parameter N_WAKE = 3,
	parameter N_ALT = 2
) (
	input wire clk,
	input wire rst,
	input wire [2:0] dev_mode,
	input wire sleep_cmd,
	input wire [N_WAKE-1:0] wake_enable_ctrl,
	input wire [N_ALT-1:0] alt_pin_as_wake,
	input wire meas_path_enable,
	input wire [N_WAKE-1:0] wake_flag_clr,
	input wire [N_WAKE-1:0] wake_source_flags,
	input wire [N_WAKE-1:0] pull_up_en,
	input wire [N_WAKE-1:0] pull_down_en,
	input wire meas_switch,
	input wire wake_irq,
	input wire wake_up_req,
	input wire spi_fail_set,
	input wire restart_req
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ==========================================
	// measurement path
	property p_sw_on; meas_path_enable && dev_mode == 3'h0 |=> meas_switch; endproperty
	a_sw_on: assert property (p_sw_on) else $error("switch stayed open");
	property p_sw_off; !meas_path_enable || dev_mode != 3'h0 |=> !meas_switch; endproperty
	a_sw_off: assert property (p_sw_off) else $error("switch closed");
	property p_meas_pull; meas_path_enable |=> pull_up_en[1:0] == 2'h0 && pull_down_en[1:0] == 2'h0; endproperty
	a_meas_pull: assert property (p_meas_pull) else $error("pull left on");
	property p_fail; sleep_cmd && meas_path_enable && !wake_enable_ctrl[2] && (|wake_enable_ctrl[1:0])
		&& alt_pin_as_wake == 2'h0 |=> spi_fail_set && restart_req; endproperty
	a_fail: assert property (p_fail) else $error("no fail and restart");
	// ==========================================
	// pulls, flags and signalling
	property p_pull_excl; (pull_up_en & pull_down_en) == '0; endproperty
	a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
	property p_hold; 1'b1 |=> (wake_source_flags & $past(wake_source_flags) & ~$past(wake_flag_clr))
		== ($past(wake_source_flags) & ~$past(wake_flag_clr)); endproperty
	a_hold: assert property (p_hold) else $error("flag lost");
	// the pulses are registered, so they reflect the mode of the cycle before
	property p_irq; wake_irq |-> $past(dev_mode) == 3'h0 || $past(dev_mode) == 3'h1; endproperty
	a_irq: assert property (p_irq) else $error("interrupt in wrong mode");
	property p_wup; wake_up_req |-> $past(dev_mode) == 3'h2 || $past(dev_mode) == 3'h3; endproperty
	a_wup: assert property (p_wup) else $error("wake in wrong mode");
endmodule // wim_wake_checker
bind wim_wake_monitor wim_wake_checker #(.N_WAKE(N_WAKE), .N_ALT(N_ALT)) chk (.clk, .rst, .dev_mode, .sleep_cmd,
	.wake_enable_ctrl, .alt_pin_as_wake, .meas_path_enable, .wake_flag_clr, .wake_source_flags, .pull_up_en,
	.pull_down_en, .meas_switch, .wake_irq, .wake_up_req, .spi_fail_set, .restart_req);

// [verif/wim_wake_monitor_bench.sv]
// self-checking bench for the wake input monitor
// assumes the switch model owns the pins and the checker is bound to the design
`include "wim_defines.vh"
`define CHK(nm, e, g) \
	begin \
		tests_run++; \
		if ((g) !== (e)) begin \
			fails++; \
			$display("MISMATCH %s exp %0h got %0h", nm, e, g); \
		end \
	end
module wim_wake_monitor_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SC = `WIM_SHORT_FILTER_CYC;
	localparam int LC = `WIM_LONG_FILTER_CYC;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic sleep_cmd = 1'h0;
	logic meas_path_enable = 1'h0;
	logic cyclic_timer_a_win = 1'h0;
	logic cyclic_timer_b_win = 1'h0;
	logic [2:0] lvl = 3'h0;
	logic [1:0] alt_lvl = 2'h0;
	logic [2:0] dev_mode = `WIM_MODE_NORMAL;
	logic [2:0] wake_enable_ctrl = 3'h7;
	logic [2:0] wake_flag_clr = 3'h0;
	logic [1:0] alt_flag_clr = 2'h0;
	logic [1:0] alt_pin_as_wake = 2'h0;
	logic [5:0] pull_source_ctrl = 6'h0;
	logic [5:0] filter_mode_ctrl = 6'h0;
	wire [2:0] hv_wake_pin, wake_source_flags, pin_level_status, pull_up_en, pull_down_en;
	wire [1:0] failsafe_out_pins, alt_pin_wake_flags;
	wire meas_switch, wake_irq, wake_up_req, spi_fail_set, restart_req;
	int fails = 0;
	int tests_run = 0;
	int n;
	// software puts each cyclic pin's supplying output on the same timer as its filter
	wire [2:0] supply_on;
	for (genvar p = 0; p < 3; p++) begin : g_sup
		assign supply_on[p] = !filter_mode_ctrl[2*p+1] ||
			(filter_mode_ctrl[2*p] ? cyclic_timer_b_win : cyclic_timer_a_win);
	end
	wim_switch_model sm (.lvl, .alt_lvl, .supply_on, .hv_wake_pin, .failsafe_out_pins);
	wim_wake_monitor dut (.clk, .rst, .hv_wake_pin, .failsafe_out_pins, .alt_pin_as_wake, .dev_mode, .sleep_cmd,
		.wake_enable_ctrl, .pull_source_ctrl, .filter_mode_ctrl, .meas_path_enable, .cyclic_timer_a_win,
		.cyclic_timer_b_win, .wake_flag_clr, .alt_flag_clr, .wake_source_flags, .alt_pin_wake_flags,
		.pin_level_status, .pull_up_en, .pull_down_en, .meas_switch, .wake_irq, .wake_up_req, .spi_fail_set,
		.restart_req);
	// ==========================================
	// clock, tasks and watchdog
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	// bounded wait for a signalled wake; n ends at lim when none came
	task automatic evt(input int lim);
		n = 0;
		while (!(wake_irq || wake_up_req) && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic clr;
		wake_flag_clr = 3'h7;
		alt_flag_clr = 2'h3;
		cyc(1);
		wake_flag_clr = 3'h0;
		alt_flag_clr = 2'h0;
		cyc(1);
	endtask
	function automatic logic [1:0] pexp(input int c, input logic l);
		return c == 0 ? 2'h0 : c == 1 ? 2'h1 : c == 2 ? 2'h2 : {l, !l};
	endfunction
	task automatic conclude;
		$display("counts: %0d checks, %0d mismatches", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		cyc(20000);
		fails++;
		conclude();
	end
	// ==========================================
	// tests
	initial begin
		cyc(5);
		rst = 1'h0;
		`CHK("rst_flags", 3'h0, wake_source_flags)
		for (int c = 0; c < 4; c++) begin
			pull_source_ctrl[5:4] = c[1:0];
			cyc(3);
			`CHK("pull", pexp(c, 1'h0), {pull_up_en[2], pull_down_en[2]})
		end
		lvl[0] = 1'h1;
		evt(SC + 40);
		`CHK("rise_time", 1'h1, n >= SC && n < SC + 40)
		`CHK("rise_flag", 3'h1, wake_source_flags)
		clr();
		lvl[0] = 1'h0;
		cyc(SC / 2);
		lvl[0] = 1'h1;
		evt(SC + 40);
		`CHK("glitch", SC + 40, n)
		lvl[0] = 1'h0;
		evt(SC + 40);
		`CHK("fall_flag", 3'h1, wake_source_flags)
		`CHK("fall_level", 1'h0, pin_level_status[0])
		$display("test edges done");
		filter_mode_ctrl[3:2] = `WIM_FLT_STATIC_LONG;
		clr();
		lvl[1] = 1'h1;
		evt(LC + 40);
		`CHK("long_time", 1'h1, n >= LC && n < LC + 40)
		wake_enable_ctrl = 3'h3;
		clr();
		lvl[2] = 1'h1;
		evt(SC + 40);
		`CHK("dis_none", SC + 40, n)
		`CHK("dis_level", 1'h1, pin_level_status[2])
		`CHK("auto_up", 2'h2, {pull_up_en[2], pull_down_en[2]})
		wake_enable_ctrl = 3'h7;
		dev_mode = `WIM_MODE_SLEEP;
		lvl[2] = 1'h0;
		evt(SC + 40);
		`CHK("sleep_wake", 2'h1, {wake_irq, wake_up_req})
		`CHK("sleep_flag", 3'h4, wake_source_flags)
		dev_mode = `WIM_MODE_FAILSAFE;
		lvl[2] = 1'h1;
		cyc(1);
		evt(SC + 40);
		`CHK("failsafe_wake", 2'h1, {wake_irq, wake_up_req})
		dev_mode = `WIM_MODE_NORMAL;
		$display("test filters done");
		filter_mode_ctrl = 6'h0e;
		clr();
		lvl[1:0] = 2'h1;
		evt(SC + 40);
		`CHK("cyc_closed", SC + 40, n)
		cyclic_timer_a_win = 1'h1;
		evt(SC + 40);
		`CHK("cyc_a", 3'h1, wake_source_flags)
		cyclic_timer_b_win = 1'h1;
		cyc(1);
		evt(SC + 40);
		`CHK("cyc_b", 3'h3, wake_source_flags)
		cyclic_timer_a_win = 1'h0;
		cyclic_timer_b_win = 1'h0;
		lvl[0] = 1'h0;
		cyc(SC + 40);
		`CHK("cyc_sample", 1'h1, pin_level_status[0])
		$display("test cyclic done");
		filter_mode_ctrl = 6'h15;
		alt_pin_as_wake = 2'h1;
		clr();
		alt_lvl[0] = 1'h1;
		cyc(SC + 20);
		`CHK("alt_flag", 2'h1, alt_pin_wake_flags)
		alt_pin_as_wake = 2'h0;
		pull_source_ctrl = 6'h3f;
		meas_path_enable = 1'h1;
		clr();
		`CHK("meas_sw", 1'h1, meas_switch)
		`CHK("alt_clr", 2'h0, alt_pin_wake_flags)
		lvl[1] = 1'h1;
		// pin two is set to the long filter here, so wait that long before looking
		cyc(LC + 40);
		`CHK("meas_flags", 3'h0, wake_source_flags)
		`CHK("meas_level", 1'h0, pin_level_status[1])
		dev_mode = `WIM_MODE_STOP;
		cyc(3);
		`CHK("meas_open", 1'h0, meas_switch)
		dev_mode = `WIM_MODE_NORMAL;
		wake_enable_ctrl = 3'h3;
		sleep_cmd = 1'h1;
		cyc(1);
		sleep_cmd = 1'h0;
		`CHK("meas_fail", 2'h3, {spi_fail_set, restart_req})
		$display("test measurement done");
		conclude();
	end
endmodule // wim_wake_monitor_bench
